/* File: logic/osb_fifo.sv */
`timescale 1ns/1ps
module osb_fifo #(
	parameter int unsigned width = 56,
	parameter int unsigned fdepth = 16
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int unsigned aw = $clog2(fdepth);
	logic [width-1:0] mem [fdepth];
	logic [aw:0] wr_ptr;
	logic [aw:0] rd_ptr;
	wire logic [aw:0] fill = wr_ptr - rd_ptr;
	wire logic push = in_valid && in_ready;
	wire logic pop = out_valid && out_ready;
	assign in_ready = fill != (aw+1)'(fdepth);
	assign out_valid = fill != '0;
	assign out_data = mem[rd_ptr[aw-1:0]];
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (push) mem[wr_ptr[aw-1:0]] <= in_data;
	end
endmodule

/* File: logic/osb_pkg.sv */
// How it works
// - physical inputs sampled each cycle, stamped
// - logical results stored same cycle, own buffer
// - prescaler slows logical, physical unaffected
// - bus-controller mode forwards only newest value
// - bus-controller: 100 us cycle, no stamps/frames, logical buffers held
// - bus-controller: one logical function per channel
// - each channel buffer holds 16 values
// - same line index shares one timestamp
// - stored timestamp belongs to line 1
// - shift register, line 16 discarded
// - wrapping counter advances per buffer update
// - N new samples push old line1 to N+1
// - 16-entry comparator bit history per channel
// - lines 1-8 low byte, 9-16 high byte
// - comparator timestamp is bit 0 low byte
// - green run indicator encodes operating state
// - red indicator on error, double-flash system error
// - channel indicator off/blink/on by condition
// - open-line detection only in voltage mode
// - configurable buffer entries in cyclic frame
// - frame 30 bytes, 14 samples
package osb_pkg;
	localparam int unsigned clk_mhz = 100;
	localparam int unsigned bc_cycle_us = 100;
	localparam int unsigned bc_cycle_clks = bc_cycle_us * clk_mhz;
	localparam int unsigned depth = 16;
	localparam int unsigned nch = 2;
	localparam int unsigned frame_bytes = 30;
	localparam int unsigned frame_samples = 14;
	localparam int unsigned blink_clks = 20000000;
	localparam int unsigned flash_clks = 2000000;
	localparam logic [15:0] rst_word = 16'h0000;
	localparam logic [7:0] rst_byte = 8'h00;

	typedef enum logic [2:0] {
		osb_st_reset = 3'b000,
		osb_st_boot = 3'b001,
		osb_st_preop = 3'b011,
		osb_st_run = 3'b010
	} osb_opstate_t;

	typedef enum logic [2:0] {
		osb_fn_pass = 3'h0,
		osb_fn_add = 3'h1,
		osb_fn_iadd = 3'h2,
		osb_fn_mul = 3'h3,
		osb_fn_imul = 3'h4
	} osb_func_t;

	typedef struct packed {
		logic [15:0] value;
		logic [31:0] stamp;
		logic [7:0] count;
	} osb_frame_word_t;

	typedef struct packed {
		logic open_line;
		logic under;
		logic over;
		logic broken;
		logic valid;
		logic current_mode;
	} osb_chan_stat_t;
endpackage

/* File: logic/osb_top.sv */
`timescale 1ns/1ps
module osb_top #(
	parameter int unsigned sample_width = 16,
	parameter int unsigned bc_clks = osb_pkg::bc_cycle_clks
) (
	input wire logic mclk,
	input wire logic srst,
	// configuration
	input wire logic bus_ctrl_mode,
	input wire logic [23:0] sample_period_clks,
	input wire logic [7:0] logic_prescale,
	input wire logic [1:0] chan_enable,
	input wire osb_pkg::osb_func_t [1:0] chan_func,
	input wire logic [3:0] frame_sel [14],
	input wire logic [3:0] frame_points,
	input wire osb_pkg::osb_opstate_t op_state,
	input wire logic error_state,
	input wire logic system_error,
	input wire osb_pkg::osb_chan_stat_t [1:0] chan_stat,
	// converter and logic results
	input wire logic [15:0] phys_in [2],
	input wire logic [15:0] logic_in [2],
	input wire logic [1:0] comp_in,
	// frame readout
	input wire logic frame_req,
	input wire logic [4:0] read_line,
	input wire logic read_logical,
	input wire logic read_chan,
	output logic [15:0] phys_line_data,
	output logic [15:0] logic_line_data,
	output logic [7:0] comparator_history_low_byte,
	output logic [7:0] comparator_history_high_byte,
	output logic [7:0] sample_update_counter,
	output logic [31:0] phys_stamp,
	output logic [31:0] logic_stamp,
	output logic [15:0] bc_latest [2],
	output logic frame_valid,
	input wire logic frame_ready,
	output logic [55:0] frame_word,
	output logic sample_overrun,
	output logic led_run,
	output logic led_err,
	output logic [1:0] led_chan
);
	localparam int unsigned dp = osb_pkg::depth;
	logic [15:0] pbuf [2][dp];
	logic [15:0] lbuf [2][dp];
	logic [dp-1:0] cbuf [2];
	logic [23:0] tick_cnt;
	logic [7:0] pre_cnt;
	logic [31:0] time_now;
	logic [7:0] cnt;
	logic [31:0] pst;
	logic [31:0] lst;
	logic [3:0] emit_idx;
	logic emit_busy;
	logic [7:0] last_frame_cnt;

	// tick source: fixed 100 us in bus-controller mode
	wire logic [23:0] period = bus_ctrl_mode ? 24'(bc_clks) : sample_period_clks;
	wire logic tick = tick_cnt == '0;
	wire logic lstep = tick && pre_cnt == '0;
	wire logic fifo_ready;
	// a frame with no points configured is refused
	wire logic frame_take = frame_req && !emit_busy && !bus_ctrl_mode && frame_points != 4'h0;
	wire logic [15:0] sel_val = pbuf[frame_sel[emit_idx][3]][frame_sel[emit_idx][2:0]];

	function automatic logic [15:0] apply_fn(input osb_pkg::osb_func_t f,
		input logic [15:0] a, input logic [15:0] b);
		logic [31:0] p;
		p = 32'(signed'(a)) * 32'(signed'(b));
		case (f)
			osb_pkg::osb_fn_add, osb_pkg::osb_fn_iadd: apply_fn = a + b;
			osb_pkg::osb_fn_mul, osb_pkg::osb_fn_imul: apply_fn = p[30:15];
			default: apply_fn = a;
		endcase
	endfunction

	always_ff @(posedge mclk) begin
		if (srst) begin
			tick_cnt <= '0;
			pre_cnt <= '0;
			time_now <= '0;
		end else begin
			time_now <= time_now + 32'h1;
			tick_cnt <= tick ? period - 24'h1 : tick_cnt - 24'h1;
			if (tick) pre_cnt <= (pre_cnt == '0) ? logic_prescale : pre_cnt - 8'h1;
		end
	end

	// shift buffers: newest into line 1, line 16 drops
	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt <= '0;
			pst <= '0;
			lst <= '0;
			for (int c = 0; c < 2; c++) begin
				cbuf[c] <= '0;
				for (int i = 0; i < dp; i++) begin
					pbuf[c][i] <= osb_pkg::rst_word;
					lbuf[c][i] <= osb_pkg::rst_word;
				end
			end
		end else begin
			if (tick) begin
				cnt <= cnt + 8'h1;
				pst <= time_now;
				for (int c = 0; c < 2; c++) begin
					if (chan_enable[c]) begin
						pbuf[c][0] <= phys_in[c];
						for (int i = 1; i < dp; i++) pbuf[c][i] <= pbuf[c][i-1];
					end
				end
			end
			if (lstep && !bus_ctrl_mode) begin
				lst <= time_now;
				for (int c = 0; c < 2; c++) begin
					lbuf[c][0] <= logic_in[c];
					cbuf[c] <= {cbuf[c][dp-2:0], comp_in[c]};
					for (int i = 1; i < dp; i++) lbuf[c][i] <= lbuf[c][i-1];
				end
			end
		end
	end

	// register outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			phys_line_data <= '0;
			logic_line_data <= '0;
			comparator_history_low_byte <= osb_pkg::rst_byte;
			comparator_history_high_byte <= osb_pkg::rst_byte;
			sample_update_counter <= '0;
			phys_stamp <= '0;
			logic_stamp <= '0;
			bc_latest[0] <= '0;
			bc_latest[1] <= '0;
		end else begin
			phys_line_data <= pbuf[read_chan][read_line[3:0]];
			logic_line_data <= lbuf[read_chan][read_line[3:0]];
			comparator_history_low_byte <= cbuf[read_chan][7:0];
			comparator_history_high_byte <= cbuf[read_chan][15:8];
			sample_update_counter <= cnt;
			phys_stamp <= bus_ctrl_mode ? '0 : pst;
			logic_stamp <= bus_ctrl_mode ? '0 : lst;
			bc_latest[0] <= apply_fn(chan_func[0], pbuf[0][0], pbuf[1][0]);
			bc_latest[1] <= apply_fn(chan_func[1], pbuf[1][0], pbuf[0][0]);
		end
	end

	// cyclic frame: selected lines pushed through fifo
	always_ff @(posedge mclk) begin
		if (srst) begin
			emit_busy <= 1'b0;
			emit_idx <= '0;
			sample_overrun <= 1'b0;
			last_frame_cnt <= '0;
		end else begin
			if (frame_take) begin
				emit_busy <= 1'b1;
				emit_idx <= '0;
				last_frame_cnt <= cnt;
			end else if (emit_busy && fifo_ready) begin
				emit_idx <= emit_idx + 4'h1;
				if (emit_idx + 4'h1 >= frame_points || emit_idx == 4'(osb_pkg::frame_samples - 1))
					emit_busy <= 1'b0;
			end
			sample_overrun <= frame_take && 8'(cnt - last_frame_cnt) > 8'(frame_points);
		end
	end

	osb_fifo #(.width(56), .fdepth(osb_pkg::depth)) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.in_valid(emit_busy),
		.in_ready(fifo_ready),
		.in_data({sel_val, pst, cnt}),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data(frame_word)
	);

	// indicators
	logic [24:0] led_cnt;
	always_ff @(posedge mclk) begin
		if (srst) led_cnt <= '0;
		else led_cnt <= led_cnt + 25'h1;
	end
	wire logic blink = led_cnt[24];
	wire logic sflash = led_cnt[24:22] == 3'h0;
	wire logic dflash = led_cnt[24:22] == 3'h0 || led_cnt[24:22] == 3'h2;
	always_ff @(posedge mclk) begin
		if (srst) begin
			led_run <= 1'b0;
			led_err <= 1'b1;
			led_chan <= '0;
		end else begin
			case (op_state)
				osb_pkg::osb_st_reset: led_run <= sflash;
				osb_pkg::osb_st_boot: led_run <= dflash;
				osb_pkg::osb_st_preop: led_run <= blink;
				osb_pkg::osb_st_run: led_run <= 1'b1;
				default: led_run <= 1'b0;
			endcase
			led_err <= system_error ? dflash : (error_state || op_state == osb_pkg::osb_st_reset);
			for (int c = 0; c < 2; c++) begin
				if (chan_stat[c].open_line && !chan_stat[c].current_mode) led_chan[c] <= 1'b0;
				else if (chan_stat[c].under || chan_stat[c].over || chan_stat[c].broken) led_chan[c] <= blink;
				else led_chan[c] <= chan_stat[c].valid;
			end
		end
	end

	property p_counter_step;
		@(posedge mclk) disable iff (srst) tick |=> cnt == $past(cnt) + 8'h1;
	endproperty
	a_counter_step: assert property (p_counter_step) else $error("counter missed tick");
	property p_shift;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[0]) |=> pbuf[0][1] == $past(pbuf[0][0]);
	endproperty
	a_shift: assert property (p_shift) else $error("buffer did not shift");
	property p_stamp;
		@(posedge mclk) disable iff (srst) tick |=> pst == $past(time_now);
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp not taken");
	property p_pre;
		@(posedge mclk) disable iff (srst) (!lstep || bus_ctrl_mode) |=> lst == $past(lst);
	endproperty
	a_pre: assert property (p_pre) else $error("logical stamp moved off step");
	property p_comp;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> cbuf[0][0] == $past(comp_in[0]);
	endproperty
	a_comp: assert property (p_comp) else $error("comparator bit lost");
	property p_bc_stamp;
		@(posedge mclk) disable iff (srst) bus_ctrl_mode [*2] |-> phys_stamp == '0;
	endproperty
	a_bc_stamp: assert property (p_bc_stamp) else $error("stamp shown in bc mode");
	property p_run;
		@(posedge mclk) disable iff (srst) op_state == osb_pkg::osb_st_run |=> led_run;
	endproperty
	a_run: assert property (p_run) else $error("run led not on");
	property p_lowbyte;
		@(posedge mclk) disable iff (srst) 1'b1 |=> comparator_history_low_byte == $past(cbuf[read_chan][7:0]);
	endproperty
	a_lowbyte: assert property (p_lowbyte) else $error("low byte mismatch");
	property p_shift1;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[1]) |=> pbuf[1][1] == $past(pbuf[1][0]);
	endproperty
	a_shift1: assert property (p_shift1) else $error("buffer 1 did not shift");
	property p_new0;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[0]) |=> pbuf[0][0] == $past(phys_in[0]);
	endproperty
	a_new0: assert property (p_new0) else $error("sample 0 not stored");
	property p_new1;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[1]) |=> pbuf[1][0] == $past(phys_in[1]);
	endproperty
	a_new1: assert property (p_new1) else $error("sample 1 not stored");
	property p_hold0;
		@(posedge mclk) disable iff (srst) !tick |=> pbuf[0][0] == $past(pbuf[0][0]);
	endproperty
	a_hold0: assert property (p_hold0) else $error("buffer moved off tick");
	property p_tail;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[0]) |=> pbuf[0][15] == $past(pbuf[0][14]);
	endproperty
	a_tail: assert property (p_tail) else $error("last line not shifted");
	property p_line_n;
		@(posedge mclk) disable iff (srst) (tick && chan_enable[0]) |=> pbuf[0][3] == $past(pbuf[0][2]);
	endproperty
	a_line_n: assert property (p_line_n) else $error("line 3 not moved down");
	property p_lnew0;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> lbuf[0][0] == $past(logic_in[0]);
	endproperty
	a_lnew0: assert property (p_lnew0) else $error("logical 0 not stored");
	property p_lnew1;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> lbuf[1][0] == $past(logic_in[1]);
	endproperty
	a_lnew1: assert property (p_lnew1) else $error("logical 1 not stored");
	property p_lshift;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> lbuf[0][1] == $past(lbuf[0][0]);
	endproperty
	a_lshift: assert property (p_lshift) else $error("logical did not shift");
	property p_lhold;
		@(posedge mclk) disable iff (srst) (!lstep || bus_ctrl_mode) |=> lbuf[0][0] == $past(lbuf[0][0]);
	endproperty
	a_lhold: assert property (p_lhold) else $error("logical moved off step");
	property p_comp1;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> cbuf[1][0] == $past(comp_in[1]);
	endproperty
	a_comp1: assert property (p_comp1) else $error("comparator 1 bit lost");
	property p_cshift;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> cbuf[0][15:1] == $past(cbuf[0][14:0]);
	endproperty
	a_cshift: assert property (p_cshift) else $error("comparator did not shift");
	property p_chold;
		@(posedge mclk) disable iff (srst) (!lstep || bus_ctrl_mode) |=> cbuf[0] == $past(cbuf[0]);
	endproperty
	a_chold: assert property (p_chold) else $error("comparator moved off step");
	property p_count_hold;
		@(posedge mclk) disable iff (srst) !tick |=> cnt == $past(cnt);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("counter moved off tick");
	property p_stamp_hold;
		@(posedge mclk) disable iff (srst) !tick |=> pst == $past(pst);
	endproperty
	a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved off tick");
	property p_lstamp;
		@(posedge mclk) disable iff (srst) (lstep && !bus_ctrl_mode) |=> lst == $past(time_now);
	endproperty
	a_lstamp: assert property (p_lstamp) else $error("logical stamp not taken");
	property p_pre_reload;
		@(posedge mclk) disable iff (srst) (tick && pre_cnt == '0) |=> pre_cnt == $past(logic_prescale);
	endproperty
	a_pre_reload: assert property (p_pre_reload) else $error("prescaler not reloaded");
	property p_period;
		@(posedge mclk) disable iff (srst) tick |=> tick_cnt == $past(period) - 24'h1;
	endproperty
	a_period: assert property (p_period) else $error("sampling period not reloaded");
	property p_bc_lstamp;
		@(posedge mclk) disable iff (srst) bus_ctrl_mode [*2] |-> logic_stamp == '0;
	endproperty
	a_bc_lstamp: assert property (p_bc_lstamp) else $error("logical stamp shown in bc mode");
	property p_highbyte;
		@(posedge mclk) disable iff (srst) 1'b1 |=> comparator_history_high_byte == $past(cbuf[read_chan][15:8]);
	endproperty
	a_highbyte: assert property (p_highbyte) else $error("high byte mismatch");
	property p_counter_out;
		@(posedge mclk) disable iff (srst) 1'b1 |=> sample_update_counter == $past(cnt);
	endproperty
	a_counter_out: assert property (p_counter_out) else $error("counter output stale");
	property p_pstamp_out;
		@(posedge mclk) disable iff (srst) !bus_ctrl_mode |=> phys_stamp == $past(pst);
	endproperty
	a_pstamp_out: assert property (p_pstamp_out) else $error("stamp output stale");
	property p_frame_take;
		@(posedge mclk) disable iff (srst) frame_take |=> emit_busy && emit_idx == '0;
	endproperty
	a_frame_take: assert property (p_frame_take) else $error("frame not started");
	property p_bc_refuse;
		@(posedge mclk) disable iff (srst) (bus_ctrl_mode && !emit_busy) |=> !emit_busy;
	endproperty
	a_bc_refuse: assert property (p_bc_refuse) else $error("frame started in bc mode");
	property p_frame_cap;
		@(posedge mclk) disable iff (srst) emit_busy |-> emit_idx < 4'(osb_pkg::frame_samples);
	endproperty
	a_frame_cap: assert property (p_frame_cap) else $error("frame longer than 14");
	property p_emit_step;
		@(posedge mclk) disable iff (srst) (emit_busy && fifo_ready) |=> emit_idx == $past(emit_idx) + 4'h1;
	endproperty
	a_emit_step: assert property (p_emit_step) else $error("frame index stuck");
	property p_overrun;
		@(posedge mclk) disable iff (srst) !frame_take |=> !sample_overrun;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun without frame");
	property p_run_reset;
		@(posedge mclk) disable iff (srst) op_state == osb_pkg::osb_st_reset |=> led_run == $past(sflash);
	endproperty
	a_run_reset: assert property (p_run_reset) else $error("reset pattern wrong");
	property p_run_boot;
		@(posedge mclk) disable iff (srst) op_state == osb_pkg::osb_st_boot |=> led_run == $past(dflash);
	endproperty
	a_run_boot: assert property (p_run_boot) else $error("boot pattern wrong");
	property p_run_preop;
		@(posedge mclk) disable iff (srst) op_state == osb_pkg::osb_st_preop |=> led_run == $past(blink);
	endproperty
	a_run_preop: assert property (p_run_preop) else $error("preop pattern wrong");
	property p_err_sys;
		@(posedge mclk) disable iff (srst) system_error |=> led_err == $past(dflash);
	endproperty
	a_err_sys: assert property (p_err_sys) else $error("system error pattern wrong");
	property p_err_lvl;
		@(posedge mclk) disable iff (srst) (!system_error && error_state) |=> led_err;
	endproperty
	a_err_lvl: assert property (p_err_lvl) else $error("error led not on");
	property p_chan_open;
		@(posedge mclk) disable iff (srst) (chan_stat[0].open_line && !chan_stat[0].current_mode) |=> !led_chan[0];
	endproperty
	a_chan_open: assert property (p_chan_open) else $error("open line led not off");
	property p_bc_pass;
		@(posedge mclk) disable iff (srst) chan_func[0] == osb_pkg::osb_fn_pass |=> bc_latest[0] == $past(pbuf[0][0]);
	endproperty
	a_bc_pass: assert property (p_bc_pass) else $error("bc pass value wrong");
endmodule

/* File: verif/osb_host_model.sv */
`timescale 1ns/1ps
module osb_host_model (
	input wire logic mclk,
	input wire logic srst,
	input wire logic slow,
	input wire logic [3:0] points,
	input wire logic frame_valid,
	input wire logic [55:0] frame_word,
	output logic frame_ready,
	output int words,
	output osb_pkg::osb_frame_word_t last_word,
	output logic lost
);
	osb_pkg::osb_frame_word_t w;
	logic [7:0] prev_count;
	assign w = frame_word;
	// slow host takes a word every other cycle
	always @(posedge mclk) begin
		if (srst) begin
			frame_ready <= 1'b0;
			words <= 0;
			lost <= 1'b0;
			prev_count <= 8'h00;
			last_word <= '0;
		end else begin
			frame_ready <= slow ? ~frame_ready : 1'b1;
			if (frame_valid && frame_ready) begin
				words <= words + 1;
				last_word <= w;
				prev_count <= w.count;
				if (8'(w.count - prev_count) > {4'h0, points}) begin
					lost <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: verif/test_oversampling_sample_buffer.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, s); end end
module test_oversampling_sample_buffer;
	logic mclk, srst, bcm, feed, frame_req, read_chan, slow, frame_valid, frame_ready;
	logic err_in, sample_overrun, led_run, led_err, lost, ovr_seen;
	logic [23:0] period;
	logic [7:0] prescale, c, last_c, cmp_lo, cmp_hi, sample_update_counter;
	logic [3:0] frame_sel [14];
	logic [3:0] frame_points;
	osb_pkg::osb_opstate_t op_state;
	osb_pkg::osb_chan_stat_t [1:0] chan_stat;
	logic [15:0] phys_in [2];
	logic [15:0] logic_in [2];
	logic [15:0] bc_latest [2];
	logic [1:0] comp_in, led_chan;
	logic [4:0] read_line;
	logic [15:0] phys_line_data, logic_line_data;
	logic [31:0] phys_stamp, logic_stamp, s0, l0, d1;
	logic [55:0] frame_word;
	osb_pkg::osb_frame_word_t last_word;
	int bad_count, checked, words, w0;

	osb_top #(.bc_clks(10)) DUT (.mclk(mclk), .srst(srst), .bus_ctrl_mode(bcm),
		.sample_period_clks(period), .logic_prescale(prescale), .chan_enable(2'b11),
		.chan_func('{osb_pkg::osb_fn_pass, osb_pkg::osb_fn_pass}), .frame_sel(frame_sel),
		.frame_points(frame_points), .op_state(op_state), .error_state(err_in),
		.system_error(1'b0), .chan_stat(chan_stat), .phys_in(phys_in), .logic_in(logic_in),
		.comp_in(comp_in), .frame_req(frame_req), .read_line(read_line),
		.read_logical(1'b0), .read_chan(read_chan), .phys_line_data(phys_line_data),
		.logic_line_data(logic_line_data), .comparator_history_low_byte(cmp_lo),
		.comparator_history_high_byte(cmp_hi), .sample_update_counter(sample_update_counter),
		.phys_stamp(phys_stamp), .logic_stamp(logic_stamp), .bc_latest(bc_latest),
		.frame_valid(frame_valid), .frame_ready(frame_ready), .frame_word(frame_word),
		.sample_overrun(sample_overrun), .led_run(led_run), .led_err(led_err),
		.led_chan(led_chan));
	osb_host_model host (.mclk(mclk), .srst(srst), .slow(slow), .points(frame_points),
		.frame_valid(frame_valid), .frame_word(frame_word), .frame_ready(frame_ready),
		.words(words), .last_word(last_word), .lost(lost));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// each sample carries its own counter value
	always @(posedge mclk) begin
		last_c <= sample_update_counter;
		ovr_seen <= srst ? 1'b0 : (ovr_seen || sample_overrun);
		if (feed && sample_update_counter !== last_c) begin
			phys_in[0] <= {8'h00, sample_update_counter};
			phys_in[1] <= {8'h80, sample_update_counter};
			logic_in[0] <= {8'h40, sample_update_counter};
			logic_in[1] <= {8'hc0, sample_update_counter};
			comp_in <= {2{sample_update_counter[3]}};
		end
	end

	function automatic logic [7:0] cexp(input logic [7:0] top);
		logic [7:0] r;
		logic [7:0] t;
		for (int k = 0; k < 8; k++) begin
			t = top - 8'(k);
			r[k] = t[3];
		end
		return r;
	endfunction

	task automatic complete_run();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic tick();
		int n;
		logic [7:0] c_old;
		n = 0;
		c_old = sample_update_counter;
		while (sample_update_counter === c_old && n < 200) begin
			@(negedge mclk);
			n++;
		end
		c = sample_update_counter;
		`CHK("count_step", c_old + 8'h01, c)
	endtask

	task automatic rd(input logic [4:0] ln, input logic ch);
		@(posedge mclk);
		read_line <= ln - 5'h01;
		read_chan <= ch;
		@(negedge mclk);
		@(negedge mclk);
	endtask

	task automatic frame(input int nw);
		int n;
		w0 = words;
		n = 0;
		@(posedge mclk);
		frame_req <= 1'b1;
		@(posedge mclk);
		frame_req <= 1'b0;
		while (words < w0 + nw && n < 100) begin
			@(negedge mclk);
			n++;
		end
		repeat (10) @(negedge mclk);
		`CHK("frame_words", nw, words - w0)
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		complete_run();
	end

	initial begin
		srst = 1'b1;
		{bcm, frame_req, read_chan, err_in, comp_in, read_line} = '0;
		feed = 1'b1;
		slow = 1'b1;
		period = 24'h000028;
		prescale = 8'h00;
		frame_points = 4'h3;
		op_state = osb_pkg::osb_st_preop;
		chan_stat = {6'b100000, 6'b000010};
		phys_in = '{16'h0000, 16'h0000};
		logic_in = '{16'h0000, 16'h0000};
		last_c = 8'h00;
		for (int i = 0; i < 14; i++) frame_sel[i] = 4'(i % 8);
		repeat (8) @(posedge mclk);
		`CHK("err_led_reset", 1'b1, led_err)
		srst <= 1'b0;
		op_state <= osb_pkg::osb_st_run;
		repeat (18) tick();
		`CHK("run_led", 1'b1, led_run)
		`CHK("err_led", 1'b0, led_err)
		`CHK("chan_led", 2'b01, led_chan)
		tick();
		for (int n = 1; n <= 16; n += 5) begin
			rd(5'(n), 1'b0);
			`CHK("phys0", {8'h00, 8'(c - 8'(n))}, phys_line_data)
			`CHK("logic0", {8'h40, 8'(c - 8'(n))}, logic_line_data)
		end
		rd(5'h02, 1'b1);
		`CHK("phys1", {8'h80, 8'(c - 8'h02)}, phys_line_data)
		`CHK("cmp_lo", cexp(c - 8'h01), cmp_lo)
		`CHK("cmp_hi", cexp(c - 8'h09), cmp_hi)
		tick();
		s0 = phys_stamp;
		tick();
		`CHK("pstamp", 32'd40, phys_stamp - s0)
		@(posedge mclk);
		prescale <= 8'h01;
		repeat (3) tick();
		s0 = phys_stamp;
		l0 = logic_stamp;
		tick();
		d1 = logic_stamp - l0;
		`CHK("lstamp_one", 1'b1, d1 == 32'd0 || d1 == 32'd80)
		tick();
		`CHK("pstamp_two", 32'd80, phys_stamp - s0)
		`CHK("lstamp_two", 32'd80, logic_stamp - l0)
		tick();
		s0 = phys_stamp;
		frame(3);
		`CHK("fvalue", {8'h00, 8'(c - 8'h03)}, last_word.value)
		`CHK("fstamp", s0, last_word.stamp)
		`CHK("fcount", c, last_word.count)
		`CHK("lost", 1'b1, lost)
		`CHK("overrun", 1'b1, ovr_seen)
		@(posedge mclk);
		frame_points <= 4'hf;
		slow <= 1'b0;
		tick();
		frame(14);
		`CHK("fvalue14", {8'h00, 8'(c - 8'h06)}, last_word.value)
		@(posedge mclk);
		feed <= 1'b0;
		bcm <= 1'b1;
		@(posedge mclk);
		phys_in[0] <= 16'h5a5a;
		phys_in[1] <= 16'h0a5a;
		repeat (45) @(negedge mclk);
		`CHK("bc_latest", 16'h5a5a, bc_latest[0])
		`CHK("bc_latest1", 16'h0a5a, bc_latest[1])
		`CHK("bc_stamp", 32'h0, phys_stamp)
		frame(0);
		@(posedge mclk);
		err_in <= 1'b1;
		@(negedge mclk);
		@(negedge mclk);
		`CHK("err_led_on", 1'b1, led_err)
		complete_run();
	end
endmodule
